// ===== shared/htc_consts.svh
`ifndef HTC_CONSTS_SVH
`define HTC_CONSTS_SVH

// register addresses
`define HTC_ADDR_MEAS_FORCE 16'h20c7
`define HTC_ADDR_ROTATION 16'h20d0
`define HTC_ADDR_HEADROOM 16'h20d1
`define HTC_ADDR_LIMITER 16'h20d2
`define HTC_ADDR_MAX_ATTEN 16'h20d3
`define HTC_ADDR_ATTACK 16'h20d4
`define HTC_ADDR_ENABLE 16'h20df

// reset values
`define HTC_RST_MEAS_FORCE 8'h00
`define HTC_RST_ROTATION 8'h00
`define HTC_RST_HEADROOM 8'h08
`define HTC_RST_LIMITER 8'h00
`define HTC_RST_MAX_ATTEN 8'h0f
`define HTC_RST_ATTACK 8'h02
`define HTC_RST_ENABLE 8'h00

// field positions
`define HTC_BIT_BATTERY_FORCE 1
`define HTC_BIT_POWER_FORCE 0
`define HTC_BIT_LIMITER_MODE 0
`define HTC_BIT_ENABLE 0
`define HTC_ROTATION_MSB 3
`define HTC_HEADROOM_MSB 4
`define HTC_THRESH_MSB 5
`define HTC_THRESH_LSB 1
`define HTC_MAX_ATTEN_MSB 3
`define HTC_ATTACK_MSB 3

// limiter mode encodings
`define HTC_MODE_DISTORTION 1'b0
`define HTC_MODE_LEVEL 1'b1

// timing: attack step at code 0, in ns, and clock period in ns
`define HTC_ATTACK_BASE_NS 20000
`define HTC_CLK_PERIOD_NS 50
`define HTC_ATTACK_BASE_CYCLES (`HTC_ATTACK_BASE_NS / `HTC_CLK_PERIOD_NS)

`endif

// ===== shared/htc_pkg.sv
package htc_pkg;

  // configuration fields handed to the gain computer
  typedef struct packed {
    logic [3:0] rotation_point;
    logic [4:0] headroom_sel;
    logic [4:0] limiter_threshold;
    logic limiter_mode;
    logic [3:0] max_attenuation;
    logic [3:0] attack_rate;
    logic enable;
  } htc_gain_cfg_type;

  // measurement converter channel enables
  typedef struct packed {
    logic battery_rail;
    logic power_rail;
  } htc_meas_type;

  typedef enum logic [2:0] {
    HTC_IDLE = 3'b001,
    HTC_HOLD = 3'b010,
    HTC_ATTACK = 3'b100
  } htc_state_type;

endpackage

// ===== rtl/htc_config.sv
`timescale 1ns/1ps
`include "htc_consts.svh"

module htc_config #(
  parameter int unsigned ATTACK_BASE_CYCLES = `HTC_ATTACK_BASE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic device_enable,
  input wire htc_pkg::htc_meas_type meas_auto_request,
  input wire logic [4:0] supply_threshold,
  input wire logic [3:0] attenuation_request,
  output htc_pkg::htc_meas_type meas_enable,
  output htc_pkg::htc_gain_cfg_type gain_cfg,
  output logic [4:0] limiter_threshold,
  output logic [3:0] attenuation,
  output logic attack_active
);

  // ==========================================================
  // register file
  // ==========================================================
  // seven byte-wide configuration registers on a plain strobe port.
  // each register keeps only the bits that carry a field; the rest
  // are forced to zero on write, so a read-back shows exactly what the
  // downstream logic will act on.
  // addresses are decoded in full: a near-miss address is dropped
  // rather than aliased onto a neighbour, which keeps stray writes
  // from another block on the same port harmless.
  // a write and a read in one cycle: the read sees the old value,
  // because both processes sample the registers before the edge.
  // reserved codes are stored as written; software must avoid them,
  // the hardware does not guard against them.
  //
  // register map summary:
  //   measurement force  - two channel force bits
  //   rotation point     - compressor knee
  //   supply headroom    - shared by compressor and limiter
  //   limiter            - mode bit and fixed threshold
  //   max attenuation    - cap on applied attenuation
  //   attack rate        - rise speed of attenuation
  //   tracking enable    - master switch for attenuation
  logic [7:0] meas_force_cfg;
  logic [7:0] rotation_cfg;
  logic [7:0] headroom_cfg;
  logic [7:0] limiter_cfg;
  logic [7:0] max_atten_cfg;
  logic [7:0] attack_cfg;
  logic [7:0] enable_cfg;

  // only documented bits are stored; reserved bits read back as zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meas_force_cfg <= `HTC_RST_MEAS_FORCE;
      rotation_cfg <= `HTC_RST_ROTATION;
      headroom_cfg <= `HTC_RST_HEADROOM;
      limiter_cfg <= `HTC_RST_LIMITER;
      max_atten_cfg <= `HTC_RST_MAX_ATTEN;
      attack_cfg <= `HTC_RST_ATTACK;
      enable_cfg <= `HTC_RST_ENABLE;
    end else if (reg_write) begin
      unique case (reg_addr)
        `HTC_ADDR_MEAS_FORCE: meas_force_cfg <= {6'h00, reg_wdata[1:0]};
        `HTC_ADDR_ROTATION: rotation_cfg <= {4'h0, reg_wdata[3:0]};
        `HTC_ADDR_HEADROOM: headroom_cfg <= {3'h0, reg_wdata[4:0]};
        `HTC_ADDR_LIMITER: limiter_cfg <= {2'h0, reg_wdata[5:0]};
        `HTC_ADDR_MAX_ATTEN: max_atten_cfg <= {4'h0, reg_wdata[3:0]};
        `HTC_ADDR_ATTACK: attack_cfg <= {4'h0, reg_wdata[3:0]};
        `HTC_ADDR_ENABLE: enable_cfg <= {7'h00, reg_wdata[0]};
        default: ; // unmapped writes are dropped
      endcase
    end
  end

  // read data one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        unique case (reg_addr)
          `HTC_ADDR_MEAS_FORCE: reg_rdata <= meas_force_cfg;
          `HTC_ADDR_ROTATION: reg_rdata <= rotation_cfg;
          `HTC_ADDR_HEADROOM: reg_rdata <= headroom_cfg;
          `HTC_ADDR_LIMITER: reg_rdata <= limiter_cfg;
          `HTC_ADDR_MAX_ATTEN: reg_rdata <= max_atten_cfg;
          `HTC_ADDR_ATTACK: reg_rdata <= attack_cfg;
          `HTC_ADDR_ENABLE: reg_rdata <= enable_cfg;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // field decode
  // ==========================================================
  // the enable, mode, cap and attack fields are pulled out once here; the
  // slew logic uses only these, while the output logic indexes the raw bytes for the rest.
  // the mode bit is compared against the level-mode encoding so that
  // a change of encoding only touches the constants header.
  // the attack period doubles per code; with the default base of 400
  // cycles the top defined code needs 400 << 13 cycles, which still
  // fits the 24-bit counter. codes 0xe and 0xf are reserved and would
  // simply give longer periods; the counter is wide enough for 0xf
  // even with the default base count of 400.
  logic tracking_on;
  logic level_mode;
  logic [3:0] max_code;
  logic [3:0] attack_code;
  assign tracking_on = enable_cfg[`HTC_BIT_ENABLE];
  assign level_mode = limiter_cfg[`HTC_BIT_LIMITER_MODE] == `HTC_MODE_LEVEL;
  assign max_code = max_atten_cfg[`HTC_MAX_ATTEN_MSB:0];
  assign attack_code = attack_cfg[`HTC_ATTACK_MSB:0];

  // cycles per dB of attack: base step doubled once per code
  function automatic logic [23:0] attack_period(input logic [3:0] code);
    logic [23:0] base;
    base = ATTACK_BASE_CYCLES[23:0];
    attack_period = base << code;
  endfunction

  // smaller of request and cap; cap code 0 is reserved and left as is
  function automatic logic [3:0] capped(input logic [3:0] req, input logic [3:0] cap);
    capped = (req > cap) ? cap : req;
  endfunction

  // ==========================================================
  // outputs to measurement converter and gain computer
  // ==========================================================
  // every output is registered, so downstream logic sees clean edges
  // one cycle after the cause; the price is one cycle of latency,
  // which is far below any audio-rate concern.
  // measurement channels: a force bit only has effect in the active
  // state. outside it both channels are held off even if the
  // automatic sequencer asks, so an idle device draws no converter
  // current. inside it the force bit and the automatic request are
  // combined, since a clear force bit must not stop automatic use.
  // gain configuration: a plain registered copy of the fields; the
  // gain computer itself decodes the codes into levels.
  // limiter threshold: chosen here so the gain computer has a single
  // threshold input whatever the mode.
  // forced or auto-requested channel runs only in the active state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meas_enable <= '0;
    end else begin
      meas_enable.battery_rail <= device_enable &
        (meas_force_cfg[`HTC_BIT_BATTERY_FORCE] | meas_auto_request.battery_rail);
      meas_enable.power_rail <= device_enable &
        (meas_force_cfg[`HTC_BIT_POWER_FORCE] | meas_auto_request.power_rail);
    end
  end

  // raw configuration fields registered for the gain computer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gain_cfg <= '0;
    end else begin
      gain_cfg.rotation_point <= rotation_cfg[`HTC_ROTATION_MSB:0];
      gain_cfg.headroom_sel <= headroom_cfg[`HTC_HEADROOM_MSB:0];
      gain_cfg.limiter_threshold <= limiter_cfg[`HTC_THRESH_MSB:`HTC_THRESH_LSB];
      gain_cfg.limiter_mode <= limiter_cfg[`HTC_BIT_LIMITER_MODE];
      gain_cfg.max_attenuation <= max_code;
      gain_cfg.attack_rate <= attack_code;
      gain_cfg.enable <= tracking_on;
    end
  end

  // distortion mode follows the supply; the fixed field is not looked at
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      limiter_threshold <= 5'h00;
    end else if (level_mode) begin
      limiter_threshold <= limiter_cfg[`HTC_THRESH_MSB:`HTC_THRESH_LSB];
    end else begin
      limiter_threshold <= supply_threshold;
    end
  end

  // ==========================================================
  // attenuation slew
  // ==========================================================
  // the requested attenuation is first limited by the programmed cap
  // and by the tracking enable; the result is the target.
  // upward moves are slowed to one db per attack period: a counter
  // runs while the machine is in the attack state and a step is taken
  // when it reaches the period less one, so steps are exactly one
  // period apart.
  // downward moves are applied at once because release shaping is
  // done outside this block; this keeps the cap and the enable
  // effective within one cycle when software lowers them.
  // states:
  //   idle   - only right after reset, leaves on the first cycle
  //   hold   - attenuation at or above target, counter cleared
  //   attack - attenuation below target, counter running
  // the counter restarts on every step and on every drop, so a new
  // rise never inherits a partial period from an earlier one.
  // attack_active mirrors the next state so it rises together with
  // the first counting cycle rather than one cycle after it.
  // hazard: a target that rises while a step is due still waits the
  // full period for each further db, which is the intended limit.
  // cap code 0 is reserved; it acts as a cap of zero, so tracking is
  // then effectively off.
  htc_pkg::htc_state_type state;
  htc_pkg::htc_state_type next_state;
  logic [23:0] step_count;
  logic [3:0] target;
  logic step_done;
  assign target = tracking_on ? capped(attenuation_request, max_code) : 4'h0;
  assign step_done = step_count >= attack_period(attack_code) - 24'h000001;

  always_comb begin
    next_state = state;
    unique case (state)
      htc_pkg::HTC_IDLE: next_state = (target > attenuation) ? htc_pkg::HTC_ATTACK
        : htc_pkg::HTC_HOLD;
      htc_pkg::HTC_HOLD: next_state = (target > attenuation) ? htc_pkg::HTC_ATTACK
        : htc_pkg::HTC_HOLD;
      htc_pkg::HTC_ATTACK: next_state = (target > attenuation) ? htc_pkg::HTC_ATTACK
        : htc_pkg::HTC_HOLD;
      default: next_state = htc_pkg::HTC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= htc_pkg::HTC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // one dB per attack period upward; release is outside this block,
  // so a lower target is taken at once
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      step_count <= 24'h000000;
      attenuation <= 4'h0;
      attack_active <= 1'b0;
    end else begin
      attack_active <= next_state == htc_pkg::HTC_ATTACK;
      if (target <= attenuation) begin
        attenuation <= target;
        step_count <= 24'h000000;
      end else if (state == htc_pkg::HTC_ATTACK && step_done) begin
        attenuation <= attenuation + 4'h1;
        step_count <= 24'h000000;
      end else if (state == htc_pkg::HTC_ATTACK) begin
        step_count <= step_count + 24'h000001;
      end else begin
        step_count <= 24'h000000;
      end
    end
  end

endmodule // htc_config

// ===== test/htc_config_chk.sv
`timescale 1ns/1ps
// ==========================================
// config outputs checker
module htc_chk #(
  parameter int unsigned ATTACK_BASE_CYCLES = 400
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic device_enable,
  input wire htc_pkg::htc_meas_type meas_auto_request,
  input wire logic [4:0] supply_threshold,
  input wire htc_pkg::htc_meas_type meas_enable,
  input wire htc_pkg::htc_gain_cfg_type gain_cfg,
  input wire logic [4:0] limiter_threshold,
  input wire logic [3:0] attenuation
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // one attack step; the shortest step period is four cycles
  sequence step_up;
    attenuation > $past(attenuation);
  endsequence
  sequence cfg_settled;
    $stable(gain_cfg) [*3];
  endsequence
  rise_rate_a: assert property (step_up |-> attenuation == $past(attenuation) + 4'h1)
    else $error("attenuation jumped");
  step_spacing_a: assert property (step_up |=> (!step_up) [*3])
    else $error("attack steps too close");
  atten_cap_a: assert property (cfg_settled |-> attenuation <= gain_cfg.max_attenuation)
    else $error("attenuation above cap");
  atten_off_a: assert property ((!gain_cfg.enable) [*3] |-> attenuation == 4'h0)
    else $error("attenuation while disabled");
  level_thresh_a: assert property ((gain_cfg.limiter_mode && $stable(gain_cfg)) [*2]
    |-> limiter_threshold == gain_cfg.limiter_threshold) else $error("fixed threshold");
  dist_thresh_a: assert property ((!gain_cfg.limiter_mode && $stable(gain_cfg)
    && $stable(supply_threshold)) [*2] |-> limiter_threshold == supply_threshold)
    else $error("tracked threshold");
  meas_off_a: assert property ((!device_enable) [*2] |-> meas_enable == 2'b00)
    else $error("channel on while inactive");
  meas_auto_a: assert property ((device_enable && $stable(meas_auto_request)) [*2]
    |-> (meas_enable & meas_auto_request) == meas_auto_request) else $error("auto lost");
  unmapped_read_a: assert property ((reg_read && reg_addr == 16'h20e0) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // htc_chk

bind htc_config htc_chk #(.ATTACK_BASE_CYCLES(ATTACK_BASE_CYCLES)) i_chk (.clk(clk),
  .reset(reset), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .device_enable(device_enable), .meas_auto_request(meas_auto_request),
  .supply_threshold(supply_threshold), .meas_enable(meas_enable), .gain_cfg(gain_cfg),
  .limiter_threshold(limiter_threshold), .attenuation(attenuation));

// ===== test/tb_headroom_tracking_config.sv
`timescale 1ns/1ps
// ==========================================
// bench signals and dut
module tb_headroom_tracking_config;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic device_enable = 1'b0;
  htc_pkg::htc_meas_type meas_auto_request = 2'b00;
  logic [4:0] supply_threshold = 5'h00;
  logic [3:0] attenuation_request = 4'h0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  htc_pkg::htc_meas_type meas_enable;
  htc_pkg::htc_gain_cfg_type gain_cfg;
  logic [4:0] limiter_threshold;
  logic [3:0] attenuation;
  logic attack_active;
  int miscompares = 0;
  int n_compared = 0;
  int cnt;
  logic [15:0] addrs [7] = '{16'h20c7, 16'h20d0, 16'h20d1, 16'h20d2, 16'h20d3, 16'h20d4, 16'h20df};
  logic [7:0] rstv [7] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h0f, 8'h02, 8'h00};
  logic [7:0] masks [7] = '{8'h03, 8'h0f, 8'h1f, 8'h3f, 8'h0f, 8'h0f, 8'h01};

  // small base count keeps attack steps short in simulation
  htc_config #(.ATTACK_BASE_CYCLES(4)) i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .device_enable(device_enable),
    .meas_auto_request(meas_auto_request), .supply_threshold(supply_threshold),
    .attenuation_request(attenuation_request), .meas_enable(meas_enable), .gain_cfg(gain_cfg),
    .limiter_threshold(limiter_threshold), .attenuation(attenuation),
    .attack_active(attack_active));

  initial begin
    forever #25 clk = ~clk;
  end

  // ==========================================
  // access and compare tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobes change at the falling edge, so the rising edge sees them settled
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    // rvalid and rdata stand for the one cycle after the strobe edge
    @(posedge clk);
    #1;
    check("rvalid", {7'h00, reg_rvalid}, 8'h01);
    check("rdata", reg_rdata, exp);
    @(negedge clk);
    reg_read = 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  // bounded wait for a given attenuation
  task automatic wait_att(input logic [3:0] v);
    cnt = 0;
    while (attenuation !== v && cnt < 300) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  task automatic conclude;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================
  // test sequence
  initial begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 7; i++) rd(addrs[i], rstv[i]);
    for (int i = 0; i < 7; i++) begin
      wr(addrs[i], 8'hff);
      rd(addrs[i], masks[i]);
    end
    wr(16'h20e0, 8'hff);
    rd(16'h20e0, 8'h00);
    // every code of the four-bit fields and headroom codes 0 to 16, reserved ones too
    for (int i = 0; i < 17; i++) begin
      wr(16'h20d0, 8'(i));
      wr(16'h20d1, 8'(i));
      wr(16'h20d3, 8'(i));
      wr(16'h20d4, 8'(i));
      settle;
      check("rotation", 8'(gain_cfg.rotation_point), 8'(i % 16));
      check("headroom", 8'(gain_cfg.headroom_sel), 8'(i));
      check("max_atten", 8'(gain_cfg.max_attenuation), 8'(i % 16));
      check("attack", 8'(gain_cfg.attack_rate), 8'(i % 16));
    end
    device_enable = 1'b1;
    wr(16'h20c7, 8'h02);
    settle;
    check("meas", 8'(meas_enable), 8'h02);
    wr(16'h20c7, 8'h01);
    settle;
    check("meas", 8'(meas_enable), 8'h01);
    device_enable = 1'b0;
    settle;
    check("meas", 8'(meas_enable), 8'h00);
    device_enable = 1'b1;
    meas_auto_request = 2'b11;
    wr(16'h20c7, 8'h00);
    settle;
    check("meas", 8'(meas_enable), 8'h03);
    supply_threshold = 5'h13;
    wr(16'h20d2, 8'h0a);
    settle;
    check("threshold", 8'(limiter_threshold), 8'h13);
    wr(16'h20d2, 8'h1f);
    settle;
    check("threshold", 8'(limiter_threshold), 8'h0f);
    // ramp at code 0: four cycles per dB with base count 4
    attenuation_request = 4'h9;
    wr(16'h20d3, 8'h05);
    wr(16'h20df, 8'h01);
    wait_att(4'h1);
    check("ramping", {7'h00, attack_active}, 8'h01);
    wait_att(4'h5);
    check("attack_time", 8'(cnt), 8'd16);
    repeat (10) @(negedge clk);
    check("capped", 8'(attenuation), 8'h05);
    check("ramp_done", {7'h00, attack_active}, 8'h00);
    wr(16'h20d3, 8'h02);
    settle;
    check("lowered", 8'(attenuation), 8'h02);
    wr(16'h20df, 8'h00);
    settle;
    check("disabled", 8'(attenuation), 8'h00);
    conclude;
  end

  // the whole run needs about three hundred cycles
  initial begin
    #500000;
    miscompares++;
    conclude;
  end
endmodule // tb_headroom_tracking_config
